// File: hdl/sasq_sequencer.sv
// conversion sequencer: discharge, acquisition, grounding and bit trials
`timescale 1ns/1ps
`include "sasq_params.svh"
module sasq_sequencer
    import sasq_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_start,
    input wire logic [1:0] i_res_mode,
    input wire logic [`SASQ_CHAN_W-1:0] i_channel,
    input wire logic i_cmp,
    output logic o_discharge,
    output logic o_acquire,
    output logic o_ground_all,
    output logic [`SASQ_RES_MAX-1:0] o_cap_ref,
    output logic [`SASQ_CHAN_W-1:0] o_analog_input_selector,
    output logic o_temp_sel,
    output logic o_busy,
    output logic o_done,
    output logic [`SASQ_RES_MAX-1:0] o_result,
    output logic o_result_temp,
    output logic [`SASQ_RES_MAX-1:0] o_temp_deg
);
    localparam logic [`SASQ_CNT_W-1:0] PERIOD_LOAD =
        `SASQ_CNT_W'(`SASQ_PERIOD_CYC - 1);
    localparam logic [`SASQ_CNT_W-1:0] ACQ_LOAD =
        `SASQ_CNT_W'(`SASQ_ACQ_CYC - 1);

    // number of trials for a resolution mode
    function automatic logic [`SASQ_IDX_W-1:0] res_bits(
        input sasq_mode_t mode
    );
        logic [`SASQ_IDX_W-1:0] n;
        n = 4'hc;
        unique case (mode)
            `SASQ_MODE_8: n = 4'h8;
            `SASQ_MODE_10: n = 4'ha;
            default: n = 4'hc;
        endcase
        return n;
    endfunction

    // true when the selected channel is the on-die temperature diode
    function automatic logic is_temp(
        input logic [`SASQ_CHAN_W-1:0] chan
    );
        return chan == `SASQ_TEMP_CHAN;
    endfunction

    sasq_sar_if sar ();

    sasq_sar_core u_core (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .sar(sar)
    );

    // ---- sequencing state
    sasq_state_t state_reg;
    sasq_state_t state_next;
    logic [`SASQ_CNT_W-1:0] step_cnt_reg;
    logic [`SASQ_CNT_W-1:0] step_cnt_next;
    logic [`SASQ_IDX_W-1:0] idx_reg;
    logic [`SASQ_IDX_W-1:0] idx_next;
    logic [`SASQ_CNT_W-1:0] rate_cnt_reg;
    logic [`SASQ_CNT_W-1:0] rate_cnt_next;
    sasq_mode_t mode_reg;
    sasq_mode_t mode_next;
    logic [`SASQ_CHAN_W-1:0] chan_reg;
    logic [`SASQ_CHAN_W-1:0] chan_next;
    logic start_ok;

    assign start_ok = i_start && (state_reg == SASQ_IDLE)
        && (rate_cnt_reg == '0);

    always_comb begin
        state_next = state_reg;
        step_cnt_next = step_cnt_reg;
        idx_next = idx_reg;
        mode_next = mode_reg;
        chan_next = chan_reg;
        unique case (state_reg)
            SASQ_IDLE: begin
                if (start_ok) begin
                    mode_next = i_res_mode;
                    chan_next = i_channel;
                    state_next = SASQ_DISCH;
                end
            end
            SASQ_DISCH: begin
                step_cnt_next = ACQ_LOAD;
                state_next = SASQ_ACQ;
            end
            SASQ_ACQ: begin
                if (step_cnt_reg == '0) begin
                    state_next = SASQ_GND;
                end else begin
                    step_cnt_next = step_cnt_reg - 1'b1;
                end
            end
            SASQ_GND: begin
                idx_next = res_bits(mode_reg) - 1'b1;
                state_next = SASQ_TRIAL;
            end
            SASQ_TRIAL: begin
                if (idx_reg == '0) begin
                    state_next = SASQ_DONE;
                end else begin
                    idx_next = idx_reg - 1'b1;
                end
            end
            SASQ_DONE: begin
                state_next = SASQ_IDLE;
            end
            default: begin
                state_next = SASQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            state_reg <= SASQ_IDLE;
            step_cnt_reg <= `SASQ_RST_CNT;
            idx_reg <= '0;
            mode_reg <= `SASQ_MODE_12;
            chan_reg <= `SASQ_RST_CHAN;
        end else begin
            state_reg <= state_next;
            step_cnt_reg <= step_cnt_next;
            idx_reg <= idx_next;
            mode_reg <= mode_next;
            chan_reg <= chan_next;
        end
    end

    // ---- throughput holdoff between accepted starts
    always_comb begin
        rate_cnt_next = rate_cnt_reg;
        if (start_ok) begin
            rate_cnt_next = PERIOD_LOAD;
        end else if (rate_cnt_reg != '0) begin
            rate_cnt_next = rate_cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            rate_cnt_reg <= `SASQ_RST_CNT;
        end else begin
            rate_cnt_reg <= rate_cnt_next;
        end
    end

    // ---- approximation register control
    always_comb begin
        sar.clear = (state_reg == SASQ_DISCH);
        sar.arm = (state_reg == SASQ_GND);
        sar.step = (state_reg == SASQ_TRIAL);
        sar.idx = (state_reg == SASQ_GND)
            ? res_bits(mode_reg) - 1'b1 : idx_reg;
        sar.cmp = i_cmp;
    end

    // ---- registered outputs
    logic disch_reg;
    logic disch_next;
    logic acq_reg;
    logic acq_next;
    logic gnd_reg;
    logic gnd_next;
    logic busy_reg;
    logic busy_next;
    logic done_reg;
    logic done_next;
    logic [`SASQ_CHAN_W-1:0] sel_reg;
    logic [`SASQ_CHAN_W-1:0] sel_next;
    logic tsel_reg;
    logic tsel_next;
    logic [`SASQ_RES_MAX-1:0] result_reg;
    logic [`SASQ_RES_MAX-1:0] result_next;
    logic rtemp_reg;
    logic rtemp_next;
    logic [`SASQ_RES_MAX-1:0] tdeg_reg;
    logic [`SASQ_RES_MAX-1:0] tdeg_next;

    always_comb begin
        logic [`SASQ_RES_MAX-1:0] final_res;
        final_res = sar.result;
        disch_next = (state_next == SASQ_DISCH);
        acq_next = (state_next == SASQ_ACQ);
        gnd_next = (state_next == SASQ_GND);
        busy_next = (state_next != SASQ_IDLE);
        done_next = 1'b0;
        sel_next = sel_reg;
        tsel_next = tsel_reg;
        result_next = result_reg;
        rtemp_next = rtemp_reg;
        tdeg_next = tdeg_reg;
        if (start_ok) begin
            sel_next = i_channel;
            tsel_next = is_temp(i_channel);
        end
        if (state_reg == SASQ_DONE) begin
            done_next = 1'b1;
            result_next = final_res;
            rtemp_next = is_temp(chan_reg);
            unique case (mode_reg)
                `SASQ_MODE_8: tdeg_next = {final_res[9:0], 2'b00};
                `SASQ_MODE_10: tdeg_next = final_res;
                default: tdeg_next = {2'b00, final_res[11:2]};
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            disch_reg <= 1'b0;
            acq_reg <= 1'b0;
            gnd_reg <= 1'b0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            sel_reg <= `SASQ_RST_CHAN;
            tsel_reg <= 1'b0;
            result_reg <= `SASQ_RST_RESULT;
            rtemp_reg <= 1'b0;
            tdeg_reg <= `SASQ_RST_RESULT;
        end else begin
            disch_reg <= disch_next;
            acq_reg <= acq_next;
            gnd_reg <= gnd_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
            sel_reg <= sel_next;
            tsel_reg <= tsel_next;
            result_reg <= result_next;
            rtemp_reg <= rtemp_next;
            tdeg_reg <= tdeg_next;
        end
    end

    assign o_discharge = disch_reg;
    assign o_acquire = acq_reg;
    assign o_ground_all = gnd_reg;
    assign o_cap_ref = sar.cap_ref;
    assign o_analog_input_selector = sel_reg;
    assign o_temp_sel = tsel_reg;
    assign o_busy = busy_reg;
    assign o_done = done_reg;
    assign o_result = result_reg;
    assign o_result_temp = rtemp_reg;
    assign o_temp_deg = tdeg_reg;
endmodule

// File: hdl/sasq_params.svh
// constants for the successive-approximation conversion sequencer
//
// Summary of operation
// - result resolution selectable as 8, 10 or 12 bits; trials equal resolution
// - aggregate conversion rate never exceeds 600 thousand samples per second
// - every conversion begins by discharging the whole capacitor array
// - then input is applied to all capacitors for the acquisition interval
// - then all capacitors go to ground before any bit trial
// - first trial puts the largest capacitor on the reference
// - first comparator decision is clocked into the result MSB
// - zero returns tested capacitor to ground; next half capacitor goes to reference
// - each later decision fills the next lower bit until resolution is done
// - conversion takes acquisition plus resolution plus three clock cycles
// - temperature step is 4 C in 8-bit mode, 1 C in 10 and 12-bit
// - channel 31 selects the internal temperature diode
`ifndef SASQ_PARAMS_SVH
`define SASQ_PARAMS_SVH

`define SASQ_CLK_HZ 50000000
`define SASQ_CLK_NS 20
`define SASQ_MAX_SPS 600000
`define SASQ_PERIOD_CYC ((`SASQ_CLK_HZ + `SASQ_MAX_SPS - 1) / `SASQ_MAX_SPS)
`define SASQ_ACQ_NS 200
`define SASQ_ACQ_CYC ((`SASQ_ACQ_NS + `SASQ_CLK_NS - 1) / `SASQ_CLK_NS)
`define SASQ_CNT_W 8

`define SASQ_RES_MAX 12
`define SASQ_IDX_W 4
`define SASQ_CHAN_W 5
`define SASQ_TEMP_CHAN 5'h1f

`define SASQ_MODE_8 2'h0
`define SASQ_MODE_10 2'h1
`define SASQ_MODE_12 2'h2

`define SASQ_RST_RESULT 12'h000
`define SASQ_RST_CHAN 5'h00
`define SASQ_RST_CNT 8'h00

`endif

// File: hdl/sasq_pkg.sv
// types shared by the conversion sequencer modules
package sasq_pkg;
    typedef enum logic [2:0] {
        SASQ_IDLE = 3'h0,
        SASQ_DISCH = 3'h1,
        SASQ_ACQ = 3'h3,
        SASQ_GND = 3'h2,
        SASQ_TRIAL = 3'h6,
        SASQ_DONE = 3'h7
    } sasq_state_t;

    typedef logic [1:0] sasq_mode_t;
endpackage

// File: hdl/sasq_sar_if.sv
// carrier between the sequencer control and the approximation register
`timescale 1ns/1ps
`include "sasq_params.svh"
interface sasq_sar_if;
    logic clear;
    logic arm;
    logic step;
    logic [`SASQ_IDX_W-1:0] idx;
    logic cmp;
    logic [`SASQ_RES_MAX-1:0] cap_ref;
    logic [`SASQ_RES_MAX-1:0] result;

    modport ctrl (
        output clear,
        output arm,
        output step,
        output idx,
        output cmp,
        input cap_ref,
        input result
    );

    modport core (
        input clear,
        input arm,
        input step,
        input idx,
        input cmp,
        output cap_ref,
        output result
    );
endinterface

// File: hdl/sasq_sar_core.sv
// approximation register: capacitor reference switches and result bits
`timescale 1ns/1ps
`include "sasq_params.svh"
module sasq_sar_core
    import sasq_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    sasq_sar_if.core sar
);
    logic [`SASQ_RES_MAX-1:0] cap_reg;
    logic [`SASQ_RES_MAX-1:0] cap_next;
    logic [`SASQ_RES_MAX-1:0] res_reg;
    logic [`SASQ_RES_MAX-1:0] res_next;

    always_comb begin
        cap_next = cap_reg;
        res_next = res_reg;
        if (sar.clear) begin
            cap_next = '0;
            res_next = '0;
        end else if (sar.arm) begin
            cap_next = '0;
            cap_next[sar.idx] = 1'b1;
        end else if (sar.step) begin
            res_next[sar.idx] = sar.cmp;
            if (!sar.cmp) begin
                cap_next[sar.idx] = 1'b0;
            end
            if (sar.idx != '0) begin
                cap_next[sar.idx - 1'b1] = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            cap_reg <= '0;
            res_reg <= `SASQ_RST_RESULT;
        end else begin
            cap_reg <= cap_next;
            res_reg <= res_next;
        end
    end

    assign sar.cap_ref = cap_reg;
    assign sar.result = res_reg;
endmodule

// File: dv/sasq_sequencer_sva.sv
// assertions on the conversion sequencer ports
`timescale 1ns/1ps
`include "sasq_params.svh"
module sasq_sequencer_sva (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_start,
    input wire logic o_discharge,
    input wire logic o_acquire,
    input wire logic o_ground_all,
    input wire logic [`SASQ_RES_MAX-1:0] o_cap_ref,
    input wire logic o_busy,
    input wire logic o_done,
    input wire logic [`SASQ_RES_MAX-1:0] o_result
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);
    sequence s_acq;
        (o_acquire && !o_discharge)[*5] ##1 o_acquire[*5];
    endsequence
    sequence s_gnd;
        o_ground_all && !o_acquire;
    endsequence
    AST_START: assert property ($rose(o_busy) |-> $past(i_start) && o_discharge ##1 o_cap_ref == 12'h000) else $error("conversion did not open with discharge");
    AST_ACQ: assert property (o_discharge |=> s_acq ##1 s_gnd) else $error("acquire or ground step wrong");
    AST_FIRST: assert property (o_ground_all |=> !o_ground_all && $onehot(o_cap_ref) && o_cap_ref >= 12'h080) else $error("first trial not one large capacitor");
    AST_SPAN: assert property ($rose(o_busy) |-> ##[21:25] o_done) else $error("conversion length wrong");
    AST_DONE_ONE: assert property (o_done |=> !o_done && !o_busy) else $error("done not a single pulse");
    AST_BUSY_HOLD: assert property (o_busy |=> o_busy || o_done) else $error("conversion cut short");
    AST_RES_HOLD: assert property ($changed(o_result) |-> o_done) else $error("result moved without done");
    AST_DONE_BUSY: assert property (o_done |-> $past(o_busy) && !o_busy && !o_ground_all) else $error("done outside conversion");
endmodule
bind sasq_sequencer sasq_sequencer_sva sasq_sequencer_sva_i (.i_clk_sys,
    .i_rst_n, .i_start, .o_discharge, .o_acquire, .o_ground_all,
    .o_cap_ref, .o_busy, .o_done, .o_result);

// File: dv/sasq_cmp_model.sv
// comparator model facing the capacitor array
`timescale 1ns/1ps
`include "sasq_params.svh"
module sasq_cmp_model (
    input wire logic i_clk_sys,
    input wire logic i_busy,
    input wire logic [`SASQ_RES_MAX-1:0] i_cap_ref,
    input wire logic [`SASQ_RES_MAX-1:0] i_level,
    output logic o_cmp
);
    logic junk_reg = 1'b0;
    always @(posedge i_clk_sys) junk_reg <= ~junk_reg;
    // outside a conversion the decision means nothing, so it wanders
    assign o_cmp = i_busy ? (i_level >= i_cap_ref) : junk_reg;
endmodule

// File: dv/sasq_sequencer_tb.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`include "sasq_params.svh"
module sasq_sequencer_tb;
    import sasq_pkg::*;
    typedef struct packed {
        logic [11:0] res;
        logic [11:0] deg;
        logic temp;
        logic [4:0] ch;
    } sasq_exp_t;
    logic i_clk_sys = 0, i_rst_n = 0, i_start = 0, i_cmp;
    sasq_mode_t i_res_mode = 2'h0;
    logic [4:0] i_channel = 5'h00, o_analog_input_selector;
    logic [11:0] level = 12'h000, o_cap_ref, o_result, o_temp_deg;
    logic o_discharge, o_acquire, o_ground_all, o_temp_sel;
    logic o_busy, o_done, o_result_temp;
    int n_errors = 0, n_tests = 0, cycles = 0;
    sasq_exp_t exp_q[$];
    sasq_exp_t cur;
    sasq_sequencer sasq_sequencer_i (.i_clk_sys, .i_rst_n, .i_start,
        .i_res_mode, .i_channel, .i_cmp, .o_discharge, .o_acquire,
        .o_ground_all, .o_cap_ref, .o_analog_input_selector, .o_temp_sel,
        .o_busy, .o_done, .o_result, .o_result_temp, .o_temp_deg);
    sasq_cmp_model sasq_cmp_model_i (.i_clk_sys, .i_busy(o_busy),
        .i_cap_ref(o_cap_ref), .i_level(level), .o_cmp(i_cmp));
    initial begin
        forever #10 i_clk_sys = ~i_clk_sys;
    end
    task automatic chk_res(input string what, input logic [11:0] e,
        input logic [11:0] g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic chk_lvl(input string what, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("FAIL %s expected %b seen %b", what, e, g);
        end
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            n_errors++;
            wrap_up();
        end
    end
    always @(negedge i_clk_sys) begin
        if (o_done === 1'b1) begin
            chk_lvl("queued", 1'b1, exp_q.size() != 0);
            cur = exp_q.pop_front();
            chk_res("result", cur.res, o_result);
            chk_res("selector", 12'(cur.ch), 12'(o_analog_input_selector));
            chk_lvl("temp", cur.temp, o_result_temp);
            chk_lvl("tsel", cur.temp, o_temp_sel);
            if (cur.temp) chk_res("deg", cur.deg, o_temp_deg);
        end
    end
    task automatic convert(input sasq_mode_t m, input logic [4:0] ch,
        input logic [11:0] v, input logic poke);
        int w, k;
        sasq_exp_t e;
        w = (m == 2'h0) ? 8 : (m == 2'h1) ? 10 : 12;
        e.res = v & ((12'h001 << w) - 12'h001);
        e.ch = ch;
        e.temp = (ch == `SASQ_TEMP_CHAN);
        e.deg = (w == 8) ? e.res << 2 : (w == 10) ? e.res : e.res >> 2;
        exp_q.push_back(e);
        level = e.res;
        i_res_mode = m;
        i_channel = ch;
        i_start = 1'b1;
        @(posedge i_clk_sys);
        #1;
        i_start = 1'b0;
        i_res_mode = sasq_mode_t'($urandom);
        i_channel = 5'($urandom);
        for (k = 0; k < 40; k++) begin
            @(posedge i_clk_sys);
            #1;
            if (o_done === 1'b1) break;
            i_start = poke && k == 4;
        end
        chk_res("latency", 12'(w + 12), 12'(k));
        @(posedge i_clk_sys);
        #1;
        i_start = poke;
        @(posedge i_clk_sys);
        #1;
        i_start = 1'b0;
        @(posedge i_clk_sys);
        #1;
        chk_lvl("busy", 1'b0, o_busy);
        repeat (70 - w) @(posedge i_clk_sys);
        #1;
        $display("conversion mode %0d channel %0d done", m, ch);
    endtask
    initial begin
        void'($urandom(94663));
        repeat (16) @(posedge i_clk_sys);
        #1;
        i_rst_n = 1'b1;
        convert(2'h0, 5'h1f, 12'hfff, 1'b1);
        convert(2'h1, 5'h00, 12'h000, 1'b0);
        convert(2'h2, 5'h1f, 12'h800, 1'b1);
        convert(2'h3, 5'h03, 12'h7ff, 1'b0);
        convert(2'h1, 5'h1f, 12'h2a5, 1'b1);
        for (int i = 0; i < 8; i++) begin
            convert(sasq_mode_t'($urandom_range(3)), 5'($urandom),
                12'($urandom), i[0]);
        end
        wrap_up();
    end
endmodule
